// File: rtl/rcsc_pkg.sv
// Constants, types and register map of the reset-cause and sleep controller.
// Assumes a classic Wishbone slave with 8-bit registers in the low byte lane.
package rcsc_pkg;

  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] RC_IDX   = 8'hb1; // reset_cause_register
  localparam logic [7:0] PCTL_IDX = 8'h87; // power_control_register
  localparam logic [7:0] KEY_IDX  = 8'h8e; // suspend_key

  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam int         WATCHDOG_OVERFLOW_FLAG_BIT  = 7;     // Watchdog overflow flag
  localparam int         POWER_ON_FLAG_BIT  = 5;     // Power-on flag
  localparam int         LOW_VOLTAGE_FLAG_BIT  = 4;     // Low-voltage flag
  localparam int         PINF_BIT  = 3;     // Pin reset flag
  localparam int         IDL_BIT   = 0;     // Idle request
  localparam int         PD_BIT    = 1;     // Powerdown request
  localparam int         GF_LO     = 2;     // General flags low bit
  localparam int         SSTAT_BIT = 6;     // Serial select bit
  localparam logic [7:0] KEY_VALUE = 8'h55; // Suspend unlock key
  localparam logic [7:0] FAULT_OP  = 8'ha5; // Opcode that faults
  localparam logic [2:0] PER_RST   = 3'h0;  // Period after any reset
  localparam logic [4:0] SYNC_RST  = 5'h01; // Pin idles high

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;  // 100 MHz system clock
  localparam int WDT_TICK_MS   = 1;   // Watchdog tick unit
  localparam int WARM_US       = 800; // Powerdown wake warm-up
  localparam int WDT_TICK_CYC  =
    (WDT_TICK_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WARM_CYC      =
    (WARM_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RCSC_RUN,   // Executing
    RCSC_ARMED, // Key written, awaiting request
    RCSC_IDLE,  // CPU clock stopped
    RCSC_PDOWN, // All clocks stopped
    RCSC_WARM   // Oscillator warming up
  } rcsc_state_t;

  typedef struct packed {
    logic wdog; // Overflow or fetch fault
    logic lvr;  // Low-voltage detect
    logic pin;  // External pin reset
  } rcsc_evt_t;

endpackage

// File: rtl/rcsc_wdog.sv
// Watchdog down-counter in millisecond ticks.
// Assumes kick_i pulses on every reset cause register access.
`timescale 1ns/10ps
module rcsc_wdog
  import rcsc_pkg::*;
#(
  parameter int TICK_CYCLES = WDT_TICK_CYC // Cycles per ms tick
)(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       en_i,   // Build option enable
  input  wire logic       kick_i, // Restart count
  input  wire logic [2:0] sel_i,  // Period select
  output logic            ovf_o   // One-cycle overflow
);

  // Period in ms for a select code
  function automatic logic [12:0] period_ms(input logic [2:0] s);
    unique case (s)
      3'h0: period_ms = 13'h1000;
      3'h1: period_ms = 13'h0400;
      3'h2: period_ms = 13'h0100;
      3'h3: period_ms = 13'h0080;
      3'h4: period_ms = 13'h0040;
      3'h5: period_ms = 13'h0010;
      3'h6: period_ms = 13'h0004;
      3'h7: period_ms = 13'h0001;
    endcase
  endfunction

  logic [31:0] pre_reg; // Tick prescaler
  logic [12:0] ms_reg;  // Remaining ms
  logic        ovf_reg; // Overflow pulse
  wire         tick  = pre_reg == 32'(TICK_CYCLES - 1);
  wire         last  = tick && ms_reg == 13'h0001;

  // Prescaler and down-counter, restarted by a kick
  always_ff @(posedge clk_i) begin
    if (rst_i || kick_i || !en_i) begin
      pre_reg <= 32'h0;
      ms_reg  <= period_ms(sel_i);
      ovf_reg <= 1'b0;
    end else begin
      pre_reg <= tick ? 32'h0 : pre_reg + 32'h1;
      ms_reg  <= last ? period_ms(sel_i) : (tick ? ms_reg - 13'h1 : ms_reg);
      ovf_reg <= last;
    end
  end

  assign ovf_o = ovf_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_WDOG_EN: assert property (@(posedge clk_i) disable iff (rst_i)
    ovf_o |-> $past(en_i))
    else $error("watchdog overflow while disabled");
  AST_WDOG_KICK: assert property (@(posedge clk_i) disable iff (rst_i)
    kick_i |=> !ovf_o)
    else $error("overflow right after a kick");

endmodule

// File: rtl/rcsc_top.sv
// Reset cause recording and idle/powerdown control with a Wishbone slave.
// Assumes rst_i is the power-on reset and the CPU pulses instr_done_i.
//
// Our own choice: the Wishbone register port.
`timescale 1ns/10ps
module rcsc_top
  import rcsc_pkg::*;
#(
  parameter int          WDT_TICK_CYCLES = WDT_TICK_CYC, // ms tick
  parameter int          WARM_CYCLES     = WARM_CYC,     // Warm-up
  parameter logic [15:0] FLASH_SIZE      = 16'h4000      // Program span
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        pin_rst_n_i,
  input  wire logic        lvr_det_i,
  input  wire logic        ext_irq_a_i,
  input  wire logic        ext_irq_b_i,
  input  wire logic        ext_irq_c_i,
  input  wire logic        irq_pend_i,
  input  wire logic        wake_timer_irq_i,
  input  wire logic        wake_timer_slow_i,
  input  wire logic        watchdog_build_option_i,
  input  wire logic        instr_done_i,
  input  wire logic        fetch_valid_i,
  input  wire logic [15:0] fetch_pc_i,
  input  wire logic [7:0]  fetch_op_i,
  output logic             cpu_clk_en_o,
  output logic             periph_clk_en_o,
  output logic             osc_en_o,
  output logic             sys_reset_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire  [4:0] raw = {ext_irq_c_i, ext_irq_b_i, ext_irq_a_i,
                     lvr_det_i, pin_rst_n_i}; // Async pins
  logic [4:0] s1_reg;   // First stage
  logic [4:0] s2_reg;   // Second stage
  logic [4:0] s3_reg;   // Third stage
  logic [4:0] filt_reg; // Agreed level

  // Three stages, level taken when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s1_reg[gi]   <= SYNC_RST[gi];
          s2_reg[gi]   <= SYNC_RST[gi];
          s3_reg[gi]   <= SYNC_RST[gi];
          filt_reg[gi] <= SYNC_RST[gi];
        end else begin
          s1_reg[gi] <= raw[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi]) begin
            filt_reg[gi] <= s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  wire pin_fall = filt_reg[0] && !s2_reg[0] && !s3_reg[0]; // Pin driven low
  wire lvr_rise = !filt_reg[1] && s2_reg[1] && s3_reg[1]; // Detector fires
  wire ext_wake = |filt_reg[4:2];                          // External irq

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic       ack_reg; // Answer to current cycle
  logic [7:0] dat_reg; // Read byte
  wire        acc    = wb_cyc_i && wb_stb_i && !ack_reg;
  wire        hit_rc = wb_adr_i[9:2] == RC_IDX;
  wire        hit_pc = wb_adr_i[9:2] == PCTL_IDX;
  wire        hit_k  = wb_adr_i[9:2] == KEY_IDX;
  wire        wr     = acc && wb_we_i && wb_sel_i[0];
  wire        wr_rc  = wr && hit_rc;
  wire        wr_pc  = wr && hit_pc;
  wire        wr_k   = wr && hit_k;
  wire  [7:0] wd     = wb_dat_i[7:0];
  wire        kick   = acc && hit_rc;
  wire        req_wr = wr_pc && (wd[IDL_BIT] || wd[PD_BIT]);

  // ----------------------------------------------------------------
  // Reset events
  // ----------------------------------------------------------------
  logic      wdt_ovf; // From watchdog
  wire       fault   = fetch_valid_i &&
                       (fetch_pc_i >= FLASH_SIZE || fetch_op_i == FAULT_OP);
  rcsc_evt_t evt;
  assign evt.wdog = wdt_ovf || fault;
  assign evt.lvr  = lvr_rise;
  assign evt.pin  = pin_fall;
  wire       any_rst = |evt;

  // ----------------------------------------------------------------
  // Reset cause register
  // ----------------------------------------------------------------
  logic       watchdog_overflow_flag_reg; // Overflow or fault seen
  logic       power_on_flag_reg; // Power-on seen
  logic       low_voltage_flag_reg; // Low voltage seen
  logic       pinf_reg; // Pin reset seen
  logic [2:0] per_reg;  // Watchdog period select

  // Zero clears, one keeps; a set in the same cycle wins
  wire watchdog_overflow_flag_next = evt.wdog || (wr_rc ? watchdog_overflow_flag_reg && wd[WATCHDOG_OVERFLOW_FLAG_BIT] : watchdog_overflow_flag_reg);
  wire power_on_flag_next = wr_rc ? power_on_flag_reg && wd[POWER_ON_FLAG_BIT] : power_on_flag_reg;
  wire low_voltage_flag_next = evt.lvr || (wr_rc ? low_voltage_flag_reg && wd[LOW_VOLTAGE_FLAG_BIT] : low_voltage_flag_reg);
  wire pinf_next = evt.pin || (wr_rc ? pinf_reg && wd[PINF_BIT] : pinf_reg);
  wire [2:0] per_next = any_rst ? PER_RST : (wr_rc ? wd[2:0] : per_reg);

  // Flags take power-on values, other resets only set their own flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      watchdog_overflow_flag_reg <= 1'b0;
      power_on_flag_reg <= 1'b1;
      low_voltage_flag_reg <= 1'b0;
      pinf_reg <= 1'b0;
      per_reg  <= PER_RST;
    end else begin
      watchdog_overflow_flag_reg <= watchdog_overflow_flag_next;
      power_on_flag_reg <= power_on_flag_next;
      low_voltage_flag_reg <= low_voltage_flag_next;
      pinf_reg <= pinf_next;
      per_reg  <= per_next;
    end
  end

  // Watchdog on the block clock, which never stops
  rcsc_wdog #(
    .TICK_CYCLES (WDT_TICK_CYCLES)
  ) u_wdog (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .en_i   (watchdog_build_option_i),
    .kick_i (kick),
    .sel_i  (per_reg),
    .ovf_o  (wdt_ovf)
  );

  // ----------------------------------------------------------------
  // Sleep control state
  // ----------------------------------------------------------------
  rcsc_state_t st_reg;    // Sleep state
  rcsc_state_t st_next;
  logic [7:0]  key_reg;   // suspend_key
  logic [7:0]  key_next;
  logic        idl_reg;   // sleep_request_bit
  logic        idl_next;
  logic        pd_reg;    // powerdown_request
  logic        pd_next;
  logic [1:0]  gf_reg;    // General flags
  logic [1:0]  gf_next;
  logic        sstat_reg; // Serial select
  logic        sstat_next;
  logic        icnt_reg;  // Key instruction retired
  logic        icnt_next;
  logic        rstp_reg;  // Reset waits for warm-up
  logic        rstp_next;
  logic        srst_next; // CPU restart pulse
  logic [31:0] warm_reg;  // Warm-up count
  wire         warm_done = warm_reg == 32'(WARM_CYCLES - 1);
  wire         slow_wake = wake_timer_irq_i && wake_timer_slow_i;
  wire         broken    = (acc && !req_wr) || (instr_done_i && icnt_reg);

  // Next state of the sleep sequencer
  always_comb begin
    st_next    = st_reg;
    key_next   = wr_k ? wd : key_reg;
    idl_next   = wr_pc ? wd[IDL_BIT] : idl_reg;
    pd_next    = wr_pc ? wd[PD_BIT] : pd_reg;
    gf_next    = wr_pc ? wd[GF_LO +: 2] : gf_reg;
    sstat_next = wr_pc ? wd[SSTAT_BIT] : sstat_reg;
    icnt_next  = icnt_reg;
    rstp_next  = rstp_reg;
    srst_next  = 1'b0;
    unique case (st_reg)
      // Running: the key arms, stray requests are dropped
      RCSC_RUN: begin
        icnt_next = 1'b0;
        if (wr_k && wd == KEY_VALUE) begin
          st_next = RCSC_ARMED;
        end else if (idl_reg || pd_reg) begin
          idl_next = 1'b0;
          pd_next  = 1'b0;
        end
      end
      // Armed: only a request write may follow, after at most one retired instruction
      RCSC_ARMED: begin
        if (instr_done_i) begin
          icnt_next = 1'b1;
        end
        if (req_wr) begin
          st_next = wd[PD_BIT] ? RCSC_PDOWN : RCSC_IDLE;
        end else if (broken) begin
          key_next = 8'h00;
          st_next  = RCSC_RUN;
        end
      end
      // Idle: any interrupt resumes the CPU
      RCSC_IDLE: begin
        if (irq_pend_i) begin
          key_next = 8'h00;
          idl_next = 1'b0;
          st_next  = RCSC_RUN;
        end
      end
      // Powerdown: external or slow timer interrupt wakes
      RCSC_PDOWN: begin
        if (ext_wake || slow_wake) begin
          st_next = RCSC_WARM;
        end
      end
      // Warm-up: clocks return when the count ends
      RCSC_WARM: begin
        if (warm_done) begin
          key_next  = 8'h00;
          idl_next  = 1'b0;
          pd_next   = 1'b0;
          st_next   = RCSC_RUN;
          srst_next = rstp_reg;
          rstp_next = 1'b0;
        end
      end
    endcase
    // Any reset clears key and requests and restarts the CPU
    if (any_rst) begin
      key_next   = 8'h00;
      idl_next   = 1'b0;
      pd_next    = 1'b0;
      gf_next    = 2'h0;
      sstat_next = 1'b0;
      if (st_reg == RCSC_PDOWN || st_reg == RCSC_WARM) begin
        st_next   = RCSC_WARM;
        rstp_next = 1'b1;
      end else begin
        st_next   = RCSC_RUN;
        srst_next = 1'b1;
      end
    end
  end

  // State registers; entering sleep resets nothing else
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg    <= RCSC_RUN;
      key_reg   <= 8'h00;
      idl_reg   <= 1'b0;
      pd_reg    <= 1'b0;
      gf_reg    <= 2'h0;
      sstat_reg <= 1'b0;
      icnt_reg  <= 1'b0;
      rstp_reg  <= 1'b0;
    end else begin
      st_reg    <= st_next;
      key_reg   <= key_next;
      idl_reg   <= idl_next;
      pd_reg    <= pd_next;
      gf_reg    <= gf_next;
      sstat_reg <= sstat_next;
      icnt_reg  <= icnt_next;
      rstp_reg  <= rstp_next;
    end
  end

  // Warm-up counter runs only in the warm state
  always_ff @(posedge clk_i) begin
    if (rst_i || st_reg != RCSC_WARM || warm_done) begin
      warm_reg <= 32'h0;
    end else begin
      warm_reg <= warm_reg + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Clock enables and restart
  // ----------------------------------------------------------------
  logic cpu_en_reg; // CPU clock gate
  logic per_en_reg; // Peripheral clock gate
  logic osc_reg;    // Oscillator run
  logic srst_reg;   // Restart pulse
  wire  cpu_run = st_next == RCSC_RUN || st_next == RCSC_ARMED;

  // Gates follow the next state so they align with st_reg
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_en_reg <= 1'b1;
      per_en_reg <= 1'b1;
      osc_reg    <= 1'b1;
      srst_reg   <= 1'b0;
    end else begin
      cpu_en_reg <= cpu_run;
      per_en_reg <= cpu_run || st_next == RCSC_IDLE;
      osc_reg    <= st_next != RCSC_PDOWN;
      srst_reg   <= srst_next;
    end
  end

  // ----------------------------------------------------------------
  // Read path and acknowledge
  // ----------------------------------------------------------------
  wire [7:0] rc_rd = {watchdog_overflow_flag_reg, 1'b0, power_on_flag_reg, low_voltage_flag_reg, pinf_reg, per_reg};
  wire [7:0] pc_rd = {1'b0, sstat_reg, 2'b00, gf_reg, pd_reg, idl_reg};
  wire [7:0] rd    = hit_rc ? rc_rd : (hit_pc ? pc_rd : (hit_k ? key_reg : 8'h00));

  // One-cycle answer; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 8'h00;
    end else begin
      ack_reg <= acc;
      dat_reg <= (acc && !wb_we_i) ? rd : 8'h00;
    end
  end

  assign wb_ack_o        = ack_reg;
  assign wb_dat_o        = {24'h0, dat_reg};
  assign cpu_clk_en_o    = cpu_en_reg;
  assign periph_clk_en_o = per_en_reg;
  assign osc_en_o        = osc_reg;
  assign sys_reset_o     = srst_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_WATCHDOG_OVERFLOW_FLAG_SET: assert property (evt.wdog |=> watchdog_overflow_flag_reg)
    else $error("overflow flag not set");
  AST_POWER_ON_FLAG_HOLD: assert property (!wr_rc |=> power_on_flag_reg == $past(power_on_flag_reg))
    else $error("power-on flag changed without write");
  AST_LOW_VOLTAGE_FLAG_SET: assert property (lvr_rise |=> low_voltage_flag_reg && !$past(evt.pin) || low_voltage_flag_reg)
    else $error("low voltage flag not set");
  AST_PINF_SET: assert property (pin_fall |=> pinf_reg && (sys_reset_o || rstp_reg))
    else $error("pin reset not recorded");
  AST_PER_CLR: assert property (any_rst |=> per_reg == PER_RST)
    else $error("period not cleared by reset");
  AST_IDLE_CLK: assert property (st_reg == RCSC_IDLE |-> !cpu_clk_en_o && periph_clk_en_o)
    else $error("idle clock gating wrong");
  AST_IDLE_IN: assert property (st_reg == RCSC_ARMED && req_wr && !wd[PD_BIT] && !any_rst
    |=> st_reg == RCSC_IDLE)
    else $error("idle not entered");
  AST_PD_WINS: assert property (st_reg == RCSC_ARMED && req_wr && wd[PD_BIT] && !any_rst
    |=> st_reg == RCSC_PDOWN && !osc_en_o)
    else $error("powerdown not entered");
  AST_STRAY: assert property (st_reg == RCSC_RUN && (idl_reg || pd_reg) && !wr
    |=> !idl_reg && !pd_reg && st_reg != RCSC_IDLE)
    else $error("stray request not dropped");
  AST_IDLE_OUT: assert property (st_reg == RCSC_IDLE && irq_pend_i && !any_rst
    |=> st_reg == RCSC_RUN && key_reg == 8'h00 && !idl_reg ##0 cpu_clk_en_o)
    else $error("idle exit wrong");
  AST_RST_CLR: assert property (any_rst |=> key_reg == 8'h00 && !idl_reg && !pd_reg)
    else $error("reset left sleep bits set");
  AST_PD_CLK: assert property (st_reg == RCSC_PDOWN |-> !periph_clk_en_o && !cpu_clk_en_o)
    else $error("clock running in powerdown");
  AST_PD_WAKE: assert property (st_reg == RCSC_PDOWN && ext_wake && !any_rst
    |=> st_reg == RCSC_WARM && osc_en_o)
    else $error("powerdown did not wake");

  COV_IDLE: cover property (st_reg == RCSC_IDLE ##1 st_reg == RCSC_RUN);
  COV_PD: cover property (st_reg == RCSC_WARM && warm_done && !rstp_reg);
  COV_WDT: cover property (wdt_ovf);
  COV_BREAK: cover property (st_reg == RCSC_ARMED && broken && !req_wr);

endmodule

// File: verif/tb_top.sv
// Testbench for the reset-cause and sleep controller, driven over Wishbone.
// Assumes shortened watchdog tick and warm-up counts set below.
`timescale 1ns/10ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tb_top
  import rcsc_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and addresses
  // ----------------------------------------------------------------
  localparam logic [9:0] A_RC  = {RC_IDX, 2'b00};   // Reset cause
  localparam logic [9:0] A_PC  = {PCTL_IDX, 2'b00}; // Power control
  localparam logic [9:0] A_KEY = {KEY_IDX, 2'b00};  // Suspend key
  logic        clk_i, rst_i, we, cyc, stb, pin_n, lvr, pend, wt, wt_slow, wdog_en, idone;
  logic        fv;                                  // Fetch valid
  logic [2:0]  irq;                                 // External wake lines
  logic [9:0]  adr;                                 // Byte address
  logic [31:0] wdat, rdat_w;                        // Bus data
  logic [15:0] pc;                                  // Fetch address
  logic [7:0]  op, q;                               // Opcode, read byte
  logic        ack, cpu_en, per_en, osc_en, srst;   // Design outputs
  int          num_errors, total_checks;            // Counters

  rcsc_top #(.WDT_TICK_CYCLES(10), .WARM_CYCLES(8)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'h1),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat_w), .wb_ack_o(ack),
    .pin_rst_n_i(pin_n), .lvr_det_i(lvr), .ext_irq_a_i(irq[0]), .ext_irq_b_i(irq[1]),
    .ext_irq_c_i(irq[2]), .irq_pend_i(pend), .wake_timer_irq_i(wt),
    .wake_timer_slow_i(wt_slow), .watchdog_build_option_i(wdog_en),
    .instr_done_i(idone), .fetch_valid_i(fv), .fetch_pc_i(pc), .fetch_op_i(op),
    .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en), .osc_en_o(osc_en),
    .sys_reset_o(srst));

  // ----------------------------------------------------------------
  // Clock and tasks
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Prints counts and verdict, ends the run
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Counts a hang as a mismatch and closes the run
  task automatic hang(input int n);
    if (n >= 1000) begin
      num_errors++;
      $display("Error at %0t: wait ran out", $time);
      give_verdict();
    end
  endtask

  // Classic single cycle, held until ack is sampled high
  task automatic bus(input logic [9:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    adr <= a; we <= w; wdat <= {24'h0, d}; cyc <= 1'b1; stb <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 1000);
    hang(n);
    q = rdat_w[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    `CHK(q, e)
  endtask

  // Waits for a reset pulse (0) or a running CPU clock (1)
  task automatic wait_on(input int w);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((w == 0 ? srst : cpu_en) !== 1'b1 && n < 1000);
    hang(n);
  endtask

  task automatic pin_reset();
    pin_n <= 1'b0;
    wait_on(0);
    pin_n <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask

  task automatic por();
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1; we = 0; cyc = 0; stb = 0; pin_n = 1; lvr = 0; pend = 0; wt = 0;
    wt_slow = 0; wdog_en = 0; idone = 0; fv = 0; irq = 3'h0; adr = 10'h0; wdat = 32'h0;
    pc = 16'h0; op = 8'h00; num_errors = 0; total_checks = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(A_RC, 8'h20);
    rd(10'h000, 8'h00);
    wr(A_RC, 8'hff);
    rd(A_RC, 8'h27);
    wr(A_RC, 8'h05);
    rd(A_RC, 8'h05);
    pin_reset();
    rd(A_RC, 8'h08);
    lvr <= 1'b1;
    wait_on(0);
    lvr <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd(A_RC, 8'h18);
    por();
    rd(A_RC, 8'h20);
    wr(A_RC, 8'h00);
    fv <= 1'b1; op <= FAULT_OP;
    @(posedge clk_i) fv <= 1'b0;
    wait_on(0);
    rd(A_RC, 8'h80);
    wr(A_RC, 8'h00);
    fv <= 1'b1; op <= 8'h00; pc <= 16'h4000;
    @(posedge clk_i) fv <= 1'b0;
    wait_on(0);
    rd(A_RC, 8'h80);
    wdog_en <= 1'b1;
    wr(A_RC, 8'h07);
    for (int i = 0; i < 6; i++) rd(A_RC, 8'h07);
    wait_on(0);
    rd(A_RC, 8'h80);
    wdog_en <= 1'b0;
    wr(A_RC, 8'h00);
    // Idle entry and interrupt exit
    wr(A_KEY, KEY_VALUE);
    wr(A_PC, 8'h01);
    `CHK({cpu_en, per_en, osc_en}, 3'b011)
    pend <= 1'b1;
    wait_on(1);
    pend <= 1'b0;
    rd(A_PC, 8'h00);
    rd(A_KEY, 8'h00);
    // Sequence broken by another access, then by instructions
    wr(A_KEY, KEY_VALUE);
    rd(A_RC, 8'h00);
    rd(A_KEY, 8'h00);
    wr(A_PC, 8'h01);
    `CHK(cpu_en, 1'b1)
    rd(A_PC, 8'h00);
    wr(A_KEY, KEY_VALUE);
    repeat (2) begin
      @(posedge clk_i) idone <= 1'b1;
      @(posedge clk_i) idone <= 1'b0;
    end
    wr(A_PC, 8'h01);
    `CHK(cpu_en, 1'b1)
    // Both requests, wake timer on fast then slow source
    wr(A_KEY, KEY_VALUE);
    wr(A_PC, 8'h03);
    `CHK({cpu_en, per_en, osc_en}, 3'b000)
    wt <= 1'b1;
    repeat (10) @(posedge clk_i);
    `CHK(osc_en, 1'b0)
    wt_slow <= 1'b1;
    wait_on(1);
    wt <= 1'b0; wt_slow <= 1'b0;
    rd(A_PC, 8'h00);
    rd(A_KEY, 8'h00);
    // Powerdown woken by each external line
    for (int i = 0; i < 3; i++) begin
      wr(A_KEY, KEY_VALUE);
      wr(A_PC, 8'h02);
      `CHK(per_en, 1'b0)
      irq <= 3'h1 << i;
      wait_on(1);
      irq <= 3'h0;
      rd(A_PC, 8'h00);
    end
    // General flags and select bit kept without a request
    wr(A_PC, 8'h4c);
    rd(A_PC, 8'h4c);
    // Pin reset while idle
    wr(A_KEY, KEY_VALUE);
    wr(A_PC, 8'h01);
    pin_reset();
    `CHK(cpu_en, 1'b1)
    rd(A_PC, 8'h00);
    rd(A_KEY, 8'h00);
    give_verdict();
  end
endmodule
